// file: rtl/paper_feed_sense_control.sv
// paper-feed sensing, cassette decode and solenoid sequencing with an APB slave
`timescale 1ns/1ps
module paper_feed_sense_control #(
  parameter int unsigned PICK_CYCLES = feed_pkg::PICK_CYCLES_DEF,
  parameter int unsigned DEBOUNCE_CYCLES = feed_pkg::DEBOUNCE_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire feed_pkg::apb_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic size_switch_upper_a,
  input wire logic size_switch_upper_b,
  input wire logic size_switch_upper_c,
  input wire logic size_switch_lower_a,
  input wire logic size_switch_lower_b,
  input wire logic size_switch_lower_c,
  input wire logic paper_out_upper_blocked,
  input wire logic paper_out_lower_blocked,
  input wire logic manual_sense_blocked,
  input wire logic feed_sense_blocked,
  input wire logic exit_sense_blocked,
  input wire logic systems_synced,
  output logic upper_pickup_solenoid,
  output logic lower_pickup_solenoid,
  output logic manual_feed_solenoid,
  output logic registration_solenoid,
  output logic irq
);
  import feed_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning
  logic [IN_W-1:0] raw_in, clean_in;

  assign raw_in = {exit_sense_blocked, feed_sense_blocked, manual_sense_blocked,
                   paper_out_lower_blocked, paper_out_upper_blocked,
                   size_switch_lower_c, size_switch_lower_b, size_switch_lower_a,
                   size_switch_upper_c, size_switch_upper_b, size_switch_upper_a};

  // every switch and sensor filtered before anything looks at it
  for (genvar i = 0; i < IN_W; i++) begin : g_db
    input_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RESET_LEVEL(IN_RESET[i])) u_db (
      .clk_sys(clk_sys), .reset_n(reset_n), .raw_in(raw_in[i]), .stable_out(clean_in[i]));
  end

  // single-tray model shares the upper switch pins
  wire logic single_tray_size_bit1 = clean_in[IN_UA];
  wire logic single_tray_size_bit2 = clean_in[IN_UB];
  wire logic single_tray_size_bit3 = clean_in[IN_UC];
  wire logic upper_tray_size_bit1 = clean_in[IN_UA];
  wire logic upper_tray_size_bit2 = clean_in[IN_UB];
  wire logic upper_tray_size_bit3 = clean_in[IN_UC];
  wire logic lower_tray_size_bit1 = clean_in[IN_LA];
  wire logic lower_tray_size_bit2 = clean_in[IN_LB];
  wire logic lower_tray_size_bit3 = clean_in[IN_LC];
  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [PAGE_W-1:0] pages_reg, pages_next;
  size_t upper_size_reg, upper_size_next;
  size_t lower_size_reg, lower_size_next;
  logic paper_out_reg, paper_out_next;
  feed_state_t state_reg, state_next;
  logic [PICK_CNT_W-1:0] pick_cnt_reg, pick_cnt_next;
  logic upper_sol_reg, upper_sol_next, lower_sol_reg, lower_sol_next;
  logic manual_sol_reg, manual_sol_next;
  logic reg_wait_reg, reg_wait_next, reg_sol_reg, reg_sol_next;
  logic feed_prev_reg, exit_prev_reg;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic irq_reg, irq_next;

  logic two_tray, manual_mode, lower_sel;
  logic feed_rise, feed_fall, exit_rise;
  logic wr_en, rd_en, pick_req;
  logic [IRQ_W-1:0] events;

  assign two_tray = ctrl_reg[CTRL_TWO_TRAY];
  assign manual_mode = ctrl_reg[CTRL_MANUAL];
  assign lower_sel = ctrl_reg[CTRL_LOWER] & two_tray;
  assign feed_rise = clean_in[IN_FEED] & ~feed_prev_reg;
  assign feed_fall = ~clean_in[IN_FEED] & feed_prev_reg;
  assign exit_rise = clean_in[IN_EXIT] & ~exit_prev_reg;
  assign wr_en = psel & penable & pwrite & ~pready_reg;
  assign rd_en = psel & penable & ~pwrite & ~pready_reg;
  assign pick_req = wr_en & (paddr == ADDR_CMD) & pwdata[CMD_PICK];
  ////////////////////////////////////////////////////////////////////////////
  // cassette decode and paper-out status
  always_comb begin
    // three switch levels form one code, low level = tab present
    if (two_tray) begin
      upper_size_next = decode_dual({upper_tray_size_bit1, upper_tray_size_bit2,
                                     upper_tray_size_bit3});
    end else begin
      upper_size_next = decode_single({single_tray_size_bit1, single_tray_size_bit2,
                                       single_tray_size_bit3});
    end
    // lower tray only exists on the two-tray model
    lower_size_next = two_tray ? decode_dual({lower_tray_size_bit1, lower_tray_size_bit2,
                                              lower_tray_size_bit3}) : SIZE_NONE;
    // absent cassette or blocked sensor on the selected tray
    if (lower_sel) begin
      paper_out_next = (lower_size_reg == SIZE_NONE) | clean_in[IN_OUT_L];
    end else begin
      paper_out_next = (upper_size_reg == SIZE_NONE) | clean_in[IN_OUT_U];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pickup and manual feed sequencer
  always_comb begin
    state_next = state_reg;
    pick_cnt_next = pick_cnt_reg;
    upper_sol_next = 1'b0;
    lower_sol_next = 1'b0;
    manual_sol_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        pick_cnt_next = '0;
        // manual paper only looked at in manual mode
        if (manual_mode && clean_in[IN_MAN] && !clean_in[IN_FEED]) begin
          state_next = ST_MANUAL;
          manual_sol_next = 1'b1;
        end else if (pick_req && !manual_mode && !paper_out_reg) begin
          state_next = ST_PICK;
          upper_sol_next = ~lower_sel;
          lower_sol_next = lower_sel;
        end
      end
      ST_PICK: begin
        // fixed clock count gives one pulse, one ring turn
        if (pick_cnt_reg >= PICK_CNT_W'(PICK_CYCLES - 1)) begin
          state_next = ST_IDLE;
          pick_cnt_next = '0;
        end else begin
          pick_cnt_next = pick_cnt_reg + 1'b1;
          upper_sol_next = upper_sol_reg;
          lower_sol_next = lower_sol_reg;
        end
      end
      ST_MANUAL: begin
        // hold until the sheet reaches the shutter sensor or mode drops
        if (clean_in[IN_FEED] || !manual_mode) begin
          state_next = ST_IDLE;
        end else begin
          manual_sol_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        pick_cnt_next = '0;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // registration shutter and page tracking
  always_comb begin
    reg_wait_next = reg_wait_reg;
    reg_sol_next = reg_sol_reg;
    // paper at the shutter starts the sync wait
    if (feed_rise) begin
      reg_wait_next = 1'b1;
    end
    // release only once the other systems are in step
    if (reg_wait_reg && systems_synced && clean_in[IN_FEED]) begin
      reg_sol_next = 1'b1;
      reg_wait_next = 1'b0;
    end
    if (feed_fall) begin
      reg_sol_next = 1'b0;
      reg_wait_next = 1'b0;
    end
    // pages registered but not yet seen at the exit
    pages_next = pages_reg;
    if (feed_rise && !(exit_rise && pages_reg != '0)) begin
      pages_next = (pages_reg == '1) ? pages_reg : pages_reg + 1'b1;
    end else if (!feed_rise && exit_rise && pages_reg != '0) begin
      pages_next = pages_reg - 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // APB slave, interrupt status and mask
  always_comb begin
    events = '0;
    events[IRQ_PAPER_OUT] = paper_out_next & ~paper_out_reg;
    events[IRQ_FEED] = feed_rise;
    events[IRQ_EXIT] = exit_rise;
    events[IRQ_MANUAL] = (state_reg == ST_IDLE) & (state_next == ST_MANUAL);
    events[IRQ_PICK_DONE] = (state_reg == ST_PICK) & (state_next == ST_IDLE);
    ctrl_next = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL: ctrl_next = pwdata[CTRL_W-1:0];
        ADDR_IRQ_MASK: irq_mask_next = pwdata[IRQ_W-1:0];
        ADDR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata[IRQ_W-1:0];
        ADDR_CMD: ;
        default: pslverr_next = 1'b1;
      endcase
    end
    // a new event wins over a write-one clear in the same cycle
    irq_stat_next = irq_stat_next | events;
    if (rd_en) begin
      prdata_next = '0;
      case (paddr)
        ADDR_CTRL: prdata_next[CTRL_W-1:0] = ctrl_reg;
        ADDR_CMD: ;
        ADDR_STATUS: begin
          prdata_next[ST_UPPER_LSB +: 3] = upper_size_reg;
          prdata_next[ST_LOWER_LSB +: 3] = lower_size_reg;
          prdata_next[ST_PAPER_OUT] = paper_out_reg;
          prdata_next[ST_BUSY] = (state_reg != ST_IDLE);
          prdata_next[ST_REG_ON] = reg_sol_reg;
          prdata_next[ST_CODE_LSB +: 8] = paper_out_reg ? PAPER_OUT_CODE : 8'h00;
        end
        ADDR_IRQ_STAT: prdata_next[IRQ_W-1:0] = irq_stat_reg;
        ADDR_IRQ_MASK: prdata_next[IRQ_W-1:0] = irq_mask_reg;
        ADDR_PAGES: prdata_next[PAGE_W-1:0] = pages_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
    irq_next = |(irq_stat_reg & irq_mask_reg);
  end
  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      pages_reg <= '0;
      upper_size_reg <= SIZE_NONE;
      lower_size_reg <= SIZE_NONE;
      paper_out_reg <= 1'b1;
      state_reg <= ST_IDLE;
      pick_cnt_reg <= '0;
      upper_sol_reg <= 1'b0;
      lower_sol_reg <= 1'b0;
      manual_sol_reg <= 1'b0;
      reg_wait_reg <= 1'b0;
      reg_sol_reg <= 1'b0;
      feed_prev_reg <= 1'b0;
      exit_prev_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      pages_reg <= pages_next;
      upper_size_reg <= upper_size_next;
      lower_size_reg <= lower_size_next;
      paper_out_reg <= paper_out_next;
      state_reg <= state_next;
      pick_cnt_reg <= pick_cnt_next;
      upper_sol_reg <= upper_sol_next;
      lower_sol_reg <= lower_sol_next;
      manual_sol_reg <= manual_sol_next;
      reg_wait_reg <= reg_wait_next;
      reg_sol_reg <= reg_sol_next;
      feed_prev_reg <= clean_in[IN_FEED];
      exit_prev_reg <= clean_in[IN_EXIT];
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      irq_reg <= irq_next;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign upper_pickup_solenoid = upper_sol_reg;
  assign lower_pickup_solenoid = lower_sol_reg;
  assign manual_feed_solenoid = manual_sol_reg;
  assign registration_solenoid = reg_sol_reg;
  assign irq = irq_reg;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_pick_last;
    state_reg == ST_PICK && pick_cnt_reg == PICK_CNT_W'(PICK_CYCLES - 1);
  endsequence
  a_pick_bounded: assert property (state_reg == ST_PICK |-> pick_cnt_reg < PICK_CNT_W'(PICK_CYCLES))
    else $error("pickup counter past its pulse length");
  a_pick_release: assert property (s_pick_last |=> !upper_pickup_solenoid && !lower_pickup_solenoid)
    else $error("pickup solenoid not released after one pulse");
  a_one_tray: assert property (!(upper_pickup_solenoid && lower_pickup_solenoid) &&
                               (!lower_pickup_solenoid || two_tray))
    else $error("wrong or both pickup solenoids on");
  a_manual_gate: assert property ($rose(manual_feed_solenoid) |-> $past(manual_mode) && $past(clean_in[IN_MAN]))
    else $error("manual solenoid on outside manual mode");
  a_reg_synced: assert property ($rose(registration_solenoid) |-> $past(systems_synced) && $past(reg_wait_reg))
    else $error("registration released before sync");
  a_absent_out: assert property (upper_size_reg == SIZE_NONE && !lower_sel |=> paper_out_reg)
    else $error("absent cassette not reported as paper out");
  a_decode_a4: assert property (!two_tray && clean_in[IN_UC:IN_UA] == 3'h2 |=> upper_size_reg == SIZE_A4)
    else $error("single tray A4 code misdecoded");
  a_feed_event: assert property (feed_rise |=> irq_stat_reg[IRQ_FEED] ##1 reg_wait_reg || reg_sol_reg || feed_fall)
    else $error("shutter paper detection not recorded");
  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");
endmodule : paper_feed_sense_control

// file: rtl/feed_pkg.sv
// constants, types and switch-code decoders for the paper-feed sense block
package feed_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned PICK_TIME_MS = 900;
  localparam int unsigned PICK_CYCLES_DEF = PICK_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned DEBOUNCE_TIME_US = 1000;
  localparam int unsigned DEBOUNCE_CYCLES_DEF = DEBOUNCE_TIME_US * CLK_MHZ;
  localparam int unsigned PICK_CNT_W = 28;
  localparam int unsigned DB_CNT_W = 18;

  // register byte addresses
  typedef logic [7:0] apb_addr_t;
  localparam apb_addr_t ADDR_CTRL = 8'h00;
  localparam apb_addr_t ADDR_CMD = 8'h04;
  localparam apb_addr_t ADDR_STATUS = 8'h08;
  localparam apb_addr_t ADDR_IRQ_STAT = 8'h0c;
  localparam apb_addr_t ADDR_IRQ_MASK = 8'h10;
  localparam apb_addr_t ADDR_PAGES = 8'h14;

  // control, command and status fields
  localparam int unsigned CTRL_TWO_TRAY = 0;
  localparam int unsigned CTRL_MANUAL = 1;
  localparam int unsigned CTRL_LOWER = 2;
  localparam int unsigned CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam int unsigned CMD_PICK = 0;
  localparam int unsigned ST_UPPER_LSB = 0;
  localparam int unsigned ST_LOWER_LSB = 4;
  localparam int unsigned ST_PAPER_OUT = 8;
  localparam int unsigned ST_BUSY = 12;
  localparam int unsigned ST_REG_ON = 13;
  localparam int unsigned ST_CODE_LSB = 16;
  localparam logic [7:0] PAPER_OUT_CODE = 8'h0b;

  // interrupt status bits
  localparam int unsigned IRQ_PAPER_OUT = 0;
  localparam int unsigned IRQ_FEED = 1;
  localparam int unsigned IRQ_EXIT = 2;
  localparam int unsigned IRQ_MANUAL = 3;
  localparam int unsigned IRQ_PICK_DONE = 4;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned PAGE_W = 4;

  // sensor vector positions
  localparam int unsigned IN_UA = 0;
  localparam int unsigned IN_UB = 1;
  localparam int unsigned IN_UC = 2;
  localparam int unsigned IN_LA = 3;
  localparam int unsigned IN_LB = 4;
  localparam int unsigned IN_LC = 5;
  localparam int unsigned IN_OUT_U = 6;
  localparam int unsigned IN_OUT_L = 7;
  localparam int unsigned IN_MAN = 8;
  localparam int unsigned IN_FEED = 9;
  localparam int unsigned IN_EXIT = 10;
  localparam int unsigned IN_W = 11;
  // switches idle high (nothing pushed), sensors idle clear
  localparam logic [IN_W-1:0] IN_RESET = 11'h03f;

  typedef enum logic [2:0] {
    SIZE_NONE = 3'h0,
    SIZE_LETTER = 3'h1,
    SIZE_LEGAL = 3'h2,
    SIZE_A4 = 3'h3,
    SIZE_B5 = 3'h4
  } size_t;

  // pin levels {bit1,bit2,bit3}, 1 = high = switch released
  localparam logic [2:0] SINGLE_A4 = 3'h2;
  localparam logic [2:0] SINGLE_B5 = 3'h4;
  localparam logic [2:0] SINGLE_LEGAL = 3'h1;
  localparam logic [2:0] SINGLE_LETTER = 3'h0;
  localparam logic [2:0] DUAL_LEGAL = 3'h6;
  localparam logic [2:0] DUAL_LETTER = 3'h7;
  localparam logic [2:0] DUAL_A4 = 3'h5;
  localparam logic [2:0] DUAL_B5 = 3'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_PICK, ST_MANUAL} feed_state_t;

  function automatic size_t decode_single(input logic [2:0] lv);
    case (lv)
      SINGLE_A4: decode_single = SIZE_A4;
      SINGLE_B5: decode_single = SIZE_B5;
      SINGLE_LEGAL: decode_single = SIZE_LEGAL;
      SINGLE_LETTER: decode_single = SIZE_LETTER;
      default: decode_single = SIZE_NONE;
    endcase
  endfunction : decode_single

  function automatic size_t decode_dual(input logic [2:0] lv);
    case (lv)
      DUAL_LEGAL: decode_dual = SIZE_LEGAL;
      DUAL_LETTER: decode_dual = SIZE_LETTER;
      DUAL_A4: decode_dual = SIZE_A4;
      DUAL_B5: decode_dual = SIZE_B5;
      default: decode_dual = SIZE_NONE;
    endcase
  endfunction : decode_dual
endpackage : feed_pkg

// file: rtl/input_debounce.sv
// one-bit synchroniser and stability filter for a switch or sensor
`timescale 1ns/1ps
module input_debounce #(
  parameter int unsigned CYCLES = 4,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic raw_in,
  output logic stable_out
);
  import feed_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic stable_reg;
  logic stable_next;
  logic [DB_CNT_W-1:0] cnt_reg;
  logic [DB_CNT_W-1:0] cnt_next;

  // change accepted only after the level held for CYCLES clocks
  always_comb begin
    stable_next = stable_reg;
    cnt_next = '0;
    if (sync_reg != stable_reg) begin
      if (cnt_next == cnt_reg || cnt_reg < DB_CNT_W'(CYCLES - 1)) begin
        cnt_next = cnt_reg + 1'b1;
      end
      if (cnt_reg >= DB_CNT_W'(CYCLES - 1)) begin
        stable_next = sync_reg;
        cnt_next = '0;
      end
    end
  end

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
      stable_reg <= RESET_LEVEL;
      cnt_reg <= '0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      stable_reg <= stable_next;
      cnt_reg <= cnt_next;
    end
  end

  assign stable_out = stable_reg;
endmodule : input_debounce

// file: tb/feed_partner.sv
// optics and drum model that reports when it is in step with the paper
`timescale 1ns/1ps
module feed_partner #(
  parameter int unsigned SYNC_DELAY = 40
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic feed_sense_blocked,
  output logic systems_synced
);
  int unsigned wait_cnt;
  ////////////////////////////////////////////////////////////////
  // drum needs time to catch up, so synced lags the paper on purpose
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 0;
      systems_synced <= 1'b0;
    end else if (feed_sense_blocked !== 1'b1) begin
      wait_cnt <= 0;
      systems_synced <= 1'b0;
    end else if (wait_cnt < SYNC_DELAY) begin
      wait_cnt <= wait_cnt + 1;
    end else begin
      systems_synced <= 1'b1;
    end
  end
endmodule : feed_partner

// file: tb/test_paper_feed_sense_control.sv
// sequence tests of the paper-feed sense block over apb and its pins
`timescale 1ns/1ps
module test_paper_feed_sense_control;
  import feed_pkg::*;
  localparam int unsigned PICK = 20;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  apb_addr_t paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [2:0] sw_u = 3'h7, sw_l = 3'h7;
  logic out_u = 0, out_l = 0, man = 0, feed = 0, ext = 0, synced, e;
  logic sol_u, sol_l, sol_m, sol_r;
  int bad_count = 0, samples_checked = 0, up_cnt = 0, lo_cnt = 0;
  logic [2:0] sl [5] = '{3'h2, 3'h4, 3'h1, 3'h0, 3'h7};
  size_t se [5] = '{SIZE_A4, SIZE_B5, SIZE_LEGAL, SIZE_LETTER, SIZE_NONE};
  logic [2:0] dl [7] = '{3'h6, 3'h7, 3'h5, 3'h3, 3'h2, 3'h4, 3'h0};
  size_t de [7] = '{SIZE_LEGAL, SIZE_LETTER, SIZE_A4, SIZE_B5, SIZE_NONE, SIZE_NONE, SIZE_NONE};
  always #2.5 clk_sys = ~clk_sys;
  // pulse lengths measured in clock cycles, sampled mid-cycle away from the launching edge
  always @(negedge clk_sys) begin
    if (sol_u === 1'b1) up_cnt++;
    if (sol_l === 1'b1) lo_cnt++;
  end
  paper_feed_sense_control #(.PICK_CYCLES(PICK), .DEBOUNCE_CYCLES(4)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .size_switch_upper_a(sw_u[2]), .size_switch_upper_b(sw_u[1]), .size_switch_upper_c(sw_u[0]),
    .size_switch_lower_a(sw_l[2]), .size_switch_lower_b(sw_l[1]), .size_switch_lower_c(sw_l[0]),
    .paper_out_upper_blocked(out_u), .paper_out_lower_blocked(out_l), .manual_sense_blocked(man),
    .feed_sense_blocked(feed), .exit_sense_blocked(ext), .systems_synced(synced),
    .upper_pickup_solenoid(sol_u), .lower_pickup_solenoid(sol_l), .manual_feed_solenoid(sol_m),
    .registration_solenoid(sol_r), .irq(irq));
  feed_partner #(.SYNC_DELAY(40)) far (.clk_sys(clk_sys), .reset_n(reset_n),
    .feed_sense_blocked(feed), .systems_synced(synced));
  ////////////////////////////////////////////////////////////////
  task conclude;
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic wr, input apb_addr_t a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    // level seen mid-cycle is what the next rising edge samples; only the watchdog ends a hang
    do begin
      @(negedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task st(input int n);
    wt(n);
    apb(1'b0, ADDR_STATUS, 32'h0);
  endtask : st
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
  initial begin
    wt(12);
    reset_n <= 1'b1;
    // single-tray decode of every listed code
    for (int i = 0; i < 5; i++) begin
      sw_u <= sl[i];
      st(16);
      chk(q[2:0], se[i]);
    end
    chk({q[23:16], 7'h0, q[8]}, {8'h0b, 8'h01});
    // paper-out interrupt raised, masked in, then cleared
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    wt(3);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    wt(3);
    chk(irq, 1'b0);
    sw_u <= 3'h0;
    st(16);
    chk({q[23:16], 7'h0, q[8]}, 16'h0);
    out_u <= 1'b1;
    st(16);
    chk({q[23:16], 7'h0, q[8]}, {8'h0b, 8'h01});
    out_u <= 1'b0;
    wt(16);
    // single pick: exact pulse on the upper solenoid only
    apb(1'b1, ADDR_CMD, 32'h1);
    wt(40);
    chk(up_cnt, PICK);
    chk(lo_cnt, 0);
    // two-tray decode, lower tray fed the same code list in reverse order
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int i = 0; i < 7; i++) begin
      sw_u <= dl[i];
      sw_l <= dl[6-i];
      st(16);
      chk(q[2:0], de[i]);
      chk(q[6:4], de[6-i]);
    end
    sw_l <= 3'h7;
    apb(1'b1, ADDR_CTRL, 32'h5);
    wt(16);
    apb(1'b1, ADDR_CMD, 32'h1);
    wt(40);
    chk(lo_cnt, PICK);
    chk(up_cnt, PICK);
    // manual paper ignored outside manual mode
    apb(1'b1, ADDR_CTRL, 32'h0);
    man <= 1'b1;
    wt(16);
    chk(sol_m, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h2);
    wt(4);
    chk(sol_m, 1'b1);
    // paper at the shutter waits for sync before release
    feed <= 1'b1;
    wt(20);
    chk({sol_m, sol_r}, 2'b00);
    wt(30);
    chk(sol_r, 1'b1);
    apb(1'b0, ADDR_PAGES, 32'h0);
    chk(q, 32'h1);
    feed <= 1'b0; man <= 1'b0; ext <= 1'b1;
    wt(16);
    ext <= 1'b0;
    wt(16);
    chk(sol_r, 1'b0);
    apb(1'b0, ADDR_PAGES, 32'h0);
    chk(q, 32'h0);
    // every event kind was seen since the paper-out clear
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h1f);
    apb(1'b0, 8'h3c, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    conclude();
  end
endmodule : test_paper_feed_sense_control
